// *** src/tpg_cfg.svh ***
`ifndef TPG_CFG_SVH
`define TPG_CFG_SVH
`define TPG_CLK_MHZ 25
// minimum level width on any command line, ns
`define TPG_MIN_PULSE_NS 500
`define TPG_MIN_PULSE_CYC ((`TPG_MIN_PULSE_NS * `TPG_CLK_MHZ + 999) / 1000)
// dead time with both commands of a phase low, ns
`define TPG_DEAD_NS 1500
`define TPG_DEAD_CYC ((`TPG_DEAD_NS * `TPG_CLK_MHZ + 999) / 1000)
// highest carrier frequency, kHz; period floor in cycles
`define TPG_CARRIER_MAX_KHZ 20
`define TPG_PERIOD_MIN_CYC \
  ((`TPG_CLK_MHZ * 1000 + `TPG_CARRIER_MAX_KHZ - 1) / `TPG_CARRIER_MAX_KHZ)
// worst-case overcurrent hold time, ns; commands must drop well inside it
`define TPG_HOLD_MIN_NS 15000
`define TPG_HOLD_MIN_CYC ((`TPG_HOLD_MIN_NS * `TPG_CLK_MHZ) / 1000)
// restart lockout after a fault stop, ms
`define TPG_RESTART_MS 2000
`define TPG_RESTART_CYC (`TPG_RESTART_MS * `TPG_CLK_MHZ * 1000)
// shortest low pulse the middle shutdown honours on the shared line, ns
`define TPG_SD_FILTER_NS 300
`define TPG_SD_FILTER_CYC ((`TPG_SD_FILTER_NS * `TPG_CLK_MHZ + 999) / 1000)
`endif

// *** src/tpg_pkg.sv ***
package tpg_pkg;
  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } tpg_cmd_s;
  typedef enum logic [1:0] {
    TPG_IDLE,
    TPG_RUN,
    TPG_FAULT,
    TPG_WAIT
  } tpg_state_e;
endpackage

// *** src/tpg_host.sv ***
`timescale 1ns/1ns
`include "tpg_cfg.svh"
// Contract
// RQ1 - commands are active high: high means on
// RQ2 - every command level held at least 0.5 us
// RQ3 - 1.5 us both-low dead time per phase
// RQ4 - carrier frequency at most 20 kHz
// RQ5 - command lines always driven, never floating
// RQ6 - outer fault pins open drain, low shuts down
// RQ7 - drop all commands within 15 us hold
// RQ8 - stop driving immediately on fault seen
// RQ9 - wait 2 s before resuming after fault
// RQ10 - middle shutdown filters lows under 300 ns
// RQ11 - middle shutdown tied to both fault pins
// RQ12 - fault line low keeps all phases off
// RQ13 - overcurrent holds fault low about 26 us
// RQ14 - high gate follows command edges
// RQ15 - synchronise fault line, latch until cleared
module tpg_host
  import tpg_pkg::*;
#(
  parameter int unsigned RESTART_CYC = `TPG_RESTART_CYC
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // user side and command outputs
  input wire logic ENABLE,
  input wire logic [15:0] PERIOD,
  input wire logic [15:0] DUTY_U,
  input wire logic [15:0] DUTY_V,
  input wire logic [15:0] DUTY_W,
  input wire logic SHUTDOWN_REQ,
  input wire logic FAULT_CLEAR,
  output tpg_cmd_s CMD,
  output logic FAULT_LATCHED,
  output logic RESTART_BLOCKED,
  output logic RUNNING,
  // shared fault line, open drain
  input wire logic FAULT_LINE_IN,
  output logic FAULT_LINE_OUT,
  output logic FAULT_LINE_OE
);
  localparam int unsigned DEAD = `TPG_DEAD_CYC;
  localparam int unsigned MINP = `TPG_MIN_PULSE_CYC;
  localparam int unsigned PMIN = `TPG_PERIOD_MIN_CYC;

  logic sync1_reg, sync2_reg;
  tpg_state_e state_reg, state_next;
  logic [15:0] cnt_reg, per_reg;
  logic [31:0] wait_reg;
  logic [2:0] hi_reg, lo_reg;
  logic [2:0] hi_want, lo_want;
  logic [7:0] dead_reg [3];
  logic [7:0] hold_reg [6];
  logic flt_reg, blk_reg, run_reg, sdo_reg;
  logic stop;

  // only the second stage is looked at; the first may be metastable
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= FAULT_LINE_IN;
      sync2_reg <= sync1_reg;
    end
  end

  // latched fault: set beats clear in the same cycle
  always_ff @(posedge CLK)
  begin
    if (RST)
      flt_reg <= 1'b0;
    else if (!sync2_reg) // RQ15 RQ8
      flt_reg <= 1'b1;
    else if (FAULT_CLEAR && state_reg == TPG_WAIT && wait_reg == 32'h0)
      flt_reg <= 1'b0;
  end

  assign stop = !sync2_reg || flt_reg;

  // carrier period is clamped to the 20 kHz floor
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      cnt_reg <= 16'h0000;
      per_reg <= 16'(PMIN);
    end
    else if (cnt_reg + 16'h0001 >= per_reg)
    begin
      cnt_reg <= 16'h0000;
      per_reg <= (PERIOD < 16'(PMIN)) ? 16'(PMIN) : PERIOD; // RQ4
    end
    else
      cnt_reg <= cnt_reg + 16'h0001;
  end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      TPG_IDLE:
        if (stop)
          state_next = TPG_FAULT;
        else if (ENABLE)
          state_next = TPG_RUN;
      TPG_RUN:
        if (stop)
          state_next = TPG_FAULT; // RQ8
        else if (!ENABLE)
          state_next = TPG_IDLE;
      TPG_FAULT:
        if (sync2_reg)
          state_next = TPG_WAIT;
      TPG_WAIT:
        if (!sync2_reg)
          state_next = TPG_FAULT;
        else if (!flt_reg)
          state_next = TPG_IDLE;
      default:
        state_next = TPG_IDLE;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      state_reg <= TPG_IDLE;
    else
      state_reg <= state_next;
  end

  // restart lockout counts from the line going high again
  always_ff @(posedge CLK)
  begin
    if (RST)
      wait_reg <= 32'h0;
    else if (state_reg == TPG_FAULT)
      wait_reg <= 32'(RESTART_CYC); // RQ9
    else if (wait_reg != 32'h0)
      wait_reg <= wait_reg - 32'h1;
  end

  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      hi_want[i] = 1'b0;
      lo_want[i] = 1'b0;
    end
    if (state_reg == TPG_RUN && !stop)
    begin
      hi_want[0] = cnt_reg < DUTY_U; // RQ1
      hi_want[1] = cnt_reg < DUTY_V;
      hi_want[2] = cnt_reg < DUTY_W;
      lo_want = ~hi_want;
    end
  end

  // per phase: dead time and minimum width, except a stop drops at once
  for (genvar p = 0; p < 3; p++)
  begin : g_ph
    always_ff @(posedge CLK)
    begin
      if (RST)
      begin
        hi_reg[p] <= 1'b0;
        lo_reg[p] <= 1'b0;
        dead_reg[p] <= 8'h00;
        hold_reg[p] <= 8'h00;
        hold_reg[p+3] <= 8'h00;
      end
      else if (stop)
      begin
        hi_reg[p] <= 1'b0; // RQ7 RQ8
        lo_reg[p] <= 1'b0;
        dead_reg[p] <= 8'(DEAD);
        hold_reg[p] <= 8'(MINP);
        hold_reg[p+3] <= 8'(MINP);
      end
      else
      begin
        if (hold_reg[p] != 8'h00)
          hold_reg[p] <= hold_reg[p] - 8'h01;
        if (hold_reg[p+3] != 8'h00)
          hold_reg[p+3] <= hold_reg[p+3] - 8'h01;
        if (dead_reg[p] != 8'h00)
          dead_reg[p] <= dead_reg[p] - 8'h01;
        if (hi_reg[p] && !hi_want[p] && hold_reg[p] == 8'h00)
        begin
          hi_reg[p] <= 1'b0; // RQ2
          hold_reg[p] <= 8'(MINP - 1);
          dead_reg[p] <= 8'(DEAD - 1); // RQ3
        end
        else if (lo_reg[p] && !lo_want[p] && hold_reg[p+3] == 8'h00)
        begin
          lo_reg[p] <= 1'b0;
          hold_reg[p+3] <= 8'(MINP - 1);
          dead_reg[p] <= 8'(DEAD - 1);
        end
        else if (!hi_reg[p] && !lo_reg[p] && dead_reg[p] == 8'h00)
        begin
          if (hi_want[p] && hold_reg[p] == 8'h00)
          begin
            hi_reg[p] <= 1'b1;
            hold_reg[p] <= 8'(MINP - 1);
          end
          else if (lo_want[p] && hold_reg[p+3] == 8'h00)
          begin
            lo_reg[p] <= 1'b1;
            hold_reg[p+3] <= 8'(MINP - 1);
          end
        end
      end
    end
  end

  // status and the host's own pull on the shared line
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      blk_reg <= 1'b0;
      run_reg <= 1'b0;
      sdo_reg <= 1'b0;
    end
    else
    begin
      blk_reg <= state_reg == TPG_FAULT || wait_reg != 32'h0;
      run_reg <= state_reg == TPG_RUN;
      sdo_reg <= SHUTDOWN_REQ; // RQ6 RQ11
    end
  end

  // lines are always driven; the flops never go to z
  assign CMD.high = hi_reg; // RQ5
  assign CMD.low = lo_reg;
  assign FAULT_LATCHED = flt_reg;
  assign RESTART_BLOCKED = blk_reg;
  assign RUNNING = run_reg;
  assign FAULT_LINE_OUT = 1'b0;
  assign FAULT_LINE_OE = sdo_reg;

  for (genvar q = 0; q < 3; q++)
  begin : g_chk
    // run lengths of the both-low gap and of the high level, saturating
    logic [7:0] gap_cnt, wid_cnt;
    always_ff @(posedge CLK)
    begin
      if (RST)
        gap_cnt <= 8'hFF;
      else if (hi_reg[q] || lo_reg[q])
        gap_cnt <= 8'h00;
      else if (gap_cnt != 8'hFF)
        gap_cnt <= gap_cnt + 8'h01;
    end
    always_ff @(posedge CLK)
    begin
      if (RST || !hi_reg[q])
        wid_cnt <= 8'h00;
      else if (wid_cnt != 8'hFF)
        wid_cnt <= wid_cnt + 8'h01;
    end
    no_overlap_a: assert property (@(posedge CLK) disable iff (RST) // RQ3
      !(hi_reg[q] && lo_reg[q]))
      else $error("both commands of a phase on");
    dead_gap_a: assert property (@(posedge CLK) disable iff (RST) // RQ3
      ($rose(hi_reg[q]) || $rose(lo_reg[q])) |-> gap_cnt >= 8'(DEAD))
      else $error("dead time too short");
    min_width_a: assert property ( // RQ2
      @(posedge CLK) disable iff (RST || stop)
      $fell(hi_reg[q]) |-> wid_cnt >= 8'(MINP))
      else $error("command pulse too short");
  end
  fault_drop_a: assert property (@(posedge CLK) disable iff (RST) // RQ7
    !sync2_reg |=> (CMD.high == 3'h0 && CMD.low == 3'h0))
    else $error("commands not dropped on fault");
  fault_latch_a: assert property (@(posedge CLK) disable iff (RST) // RQ15
    !sync2_reg |=> flt_reg)
    else $error("fault not latched");
  sync_path_a: assert property (@(posedge CLK) disable iff (RST) // RQ15
    $fell(FAULT_LINE_IN) ##1 !FAULT_LINE_IN |=> !sync2_reg)
    else $error("fault synchroniser delay wrong");
  restart_lock_a: assert property (@(posedge CLK) disable iff (RST) // RQ9
    (state_reg == TPG_WAIT && wait_reg != 32'h0) |-> flt_reg)
    else $error("fault cleared during lockout");
  stop_run_a: assert property (@(posedge CLK) disable iff (RST) // RQ8
    (state_reg == TPG_FAULT) |-> (hi_reg == 3'h0 && lo_reg == 3'h0))
    else $error("driving while stopped");
endmodule

// *** verification/tpg_dev_model.sv ***
`timescale 1ns/1ns
`include "tpg_cfg.svh"
module tpg_dev_model
  import tpg_pkg::*;
#(
  parameter int HOLD_CYC = 650
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command pins, overcurrent trip and shared fault line
  input wire tpg_cmd_s cmd,
  input wire logic line,
  input wire logic oc_trip,
  output logic pull,
  // gate drives, high sides above low sides, and rule hits
  output logic [5:0] gates,
  output int n_viol
);
  logic [5:0] cmd_v, cmd_q, chg, rise;
  logic [2:0] off;
  int hold_cnt, low_cnt;
  int lvl_cnt [6];
  int gap_cnt [3];
  assign cmd_v = {cmd.high, cmd.low};
  assign chg = (cmd_v ^ cmd_q) & {6{~rst}};
  assign rise = chg & cmd_v;
  assign pull = hold_cnt != 0;
  // v phase ignores lows shorter than the filter
  assign off = {~line, low_cnt >= `TPG_SD_FILTER_CYC, ~line};
  assign gates = cmd_v & ~{off, off};
  always_ff @(posedge clk)
  begin
    low_cnt <= line ? 0 : low_cnt + 1;
    if (rst)
      hold_cnt <= 0;
    else if (oc_trip)
      hold_cnt <= HOLD_CYC;
    else if (hold_cnt != 0)
      hold_cnt <= hold_cnt - 1;
  end
  // widths count samples of a level; drops during a fault are exempt
  always_ff @(posedge clk)
  begin
    cmd_q <= cmd_v;
    if (rst)
      n_viol <= 0;
    else if ($isunknown(cmd))
      n_viol <= n_viol + 1;
    for (int i = 0; i < 6; i++)
    begin
      lvl_cnt[i] <= rst ? 1000 : chg[i] ? 1 : lvl_cnt[i] + 1;
      if (line && chg[i] && lvl_cnt[i] < `TPG_MIN_PULSE_CYC)
        n_viol <= n_viol + 1;
    end
    for (int p = 0; p < 3; p++)
    begin
      gap_cnt[p] <= rst ? 1000 : cmd_v[p] | cmd_v[p + 3] ? 0 : gap_cnt[p] + 1;
      if ((rise[p] | rise[p + 3]) && gap_cnt[p] < `TPG_DEAD_CYC)
        n_viol <= n_viol + 1;
    end
  end
endmodule

// *** verification/three_phase_gate_cmd_fault_if_tb_top.sv ***
`timescale 1ns/1ns
module three_phase_gate_cmd_fault_if_tb_top;
  import tpg_pkg::*;
  logic CLK = 1'h0, RST = 1'h1, ENABLE = 1'h0, oc_trip = 1'h0;
  logic SHUTDOWN_REQ = 1'h0, FAULT_CLEAR = 1'h0;
  // period below the floor, so the carrier must clamp
  logic [15:0] PERIOD = 16'h0064, DUTY_U = 16'h0190;
  logic [15:0] DUTY_V = 16'h0271, DUTY_W = 16'h0384;
  tpg_cmd_s CMD;
  logic FAULT_LATCHED, RESTART_BLOCKED, RUNNING, FAULT_LINE_OUT;
  logic FAULT_LINE_OE, pull, line;
  logic [5:0] gates;
  int n_viol, n_fail, check_count, a, b;
  // pulled-up line, low while either side pulls
  assign line = ~((FAULT_LINE_OE & ~FAULT_LINE_OUT) | pull);
  tpg_host #(.RESTART_CYC(200)) i_tpg_host (.CLK(CLK), .RST(RST),
    .ENABLE(ENABLE), .PERIOD(PERIOD), .DUTY_U(DUTY_U), .DUTY_V(DUTY_V),
    .DUTY_W(DUTY_W), .SHUTDOWN_REQ(SHUTDOWN_REQ), .FAULT_CLEAR(FAULT_CLEAR),
    .CMD(CMD), .FAULT_LATCHED(FAULT_LATCHED), .RUNNING(RUNNING),
    .RESTART_BLOCKED(RESTART_BLOCKED), .FAULT_LINE_IN(line),
    .FAULT_LINE_OUT(FAULT_LINE_OUT), .FAULT_LINE_OE(FAULT_LINE_OE));
  tpg_dev_model i_tpg_dev_model (.clk(CLK), .rst(RST), .cmd(CMD),
    .line(line), .oc_trip(oc_trip), .pull(pull), .gates(gates),
    .n_viol(n_viol));
  initial forever #20 CLK = ~CLK;
  function automatic logic cond(int s);
    case (s)
      0: return CMD === 6'h00;
      1: return line === 1'h1;
      2: return FAULT_LATCHED === 1'h0;
      3: return RUNNING === 1'h1;
      4: return CMD.high[0] === 1'h1;
      default: return CMD.high[0] === 1'h0;
    endcase
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded wait; running out ends the run
  task automatic wait_on(int s, int lim, output int n);
    n = 0;
    while (!cond(s) && n < lim)
    begin
      @(posedge CLK);
      #1;
      n++;
    end
    chk("wait", 16'h0001, 16'(cond(s)));
    if (!cond(s))
      final_report();
  endtask
  task automatic pulse_clear();
    @(posedge CLK);
    FAULT_CLEAR <= 1'h1;
    @(posedge CLK);
    FAULT_CLEAR <= 1'h0;
    repeat (4) @(posedge CLK);
    #1;
  endtask
  task automatic recover();
    wait_on(1, 800, a);
    pulse_clear();
    chk("early clear", 16'h0001, 16'(FAULT_LATCHED));
    repeat (220) @(posedge CLK);
    pulse_clear();
    wait_on(2, 10, a);
    wait_on(3, 20, a);
    chk("blocked", 16'h0000, 16'(RESTART_BLOCKED));
  endtask
  task automatic t_run();
    wait_on(3, 5, a);
    wait_on(5, 1300, a);
    wait_on(4, 1300, a);
    wait_on(5, 1300, a);
    wait_on(4, 1300, b);
    chk("carrier period", 16'h04E2, 16'(a + b));
    $display("t_run done");
  endtask
  task automatic t_oc();
    @(posedge CLK);
    oc_trip <= 1'h1;
    @(posedge CLK);
    oc_trip <= 1'h0;
    #1;
    wait_on(0, 5, a);
    chk("latched", 16'h0001, 16'(FAULT_LATCHED));
    repeat (100) @(posedge CLK);
    #1;
    chk("cmd held off", 16'h0000, 16'(CMD));
    chk("blocked", 16'h0001, 16'(RESTART_BLOCKED));
    recover();
    $display("t_oc done");
  endtask
  task automatic t_shut();
    wait_on(4, 1300, a);
    @(posedge CLK);
    SHUTDOWN_REQ <= 1'h1;
    #1;
    wait_on(0, 6, a);
    chk("pulling", 16'h0001, 16'(FAULT_LINE_OE));
    chk("line out", 16'h0000, 16'(FAULT_LINE_OUT));
    chk("line", 16'h0000, 16'(line));
    repeat (10) @(posedge CLK);
    #1;
    chk("gates", 16'h0000, 16'(gates));
    @(posedge CLK);
    SHUTDOWN_REQ <= 1'h0;
    recover();
    chk("rule hits", 16'h0000, 16'(n_viol));
    $display("t_shut done");
  endtask
  initial
  begin
    repeat (10) @(posedge CLK);
    RST <= 1'h0;
    @(posedge CLK);
    ENABLE <= 1'h1;
    t_run();
    t_oc();
    t_shut();
    final_report();
  end
endmodule
